// ### design/csd_card_end.sv
/*
  card end: holds the card specific data register, answers link commands,
  guards writes and erases, and decodes the fields for the card core.
  assumes commands arrive as one-cycle pulses on the link, one at a time.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
// What this block does
// RULE1: minimum current codes map 0.5 to 100 mA
// RULE2: maximum current codes map 1 to 200 mA
// RULE3: size factor is two to code plus two
// RULE4: sector size is stored blocks minus one
// RULE5: erase group is stored sectors minus one
// RULE6: protect group is stored erase groups minus one
// RULE7: group protection refused when enable bit clear
// RULE8: default ecc fixed, same coding as ecc
// RULE9: write time is read time times two^code
// RULE10: write block length decoded like read length
// RULE11: block length two^code bytes, 12-15 reserved
// RULE12: partial bit gates transfers shorter than block
// RULE13: copy flag once set never clears
// RULE14: permanent lock rejects writes and erases forever
// RULE15: temporary lock settable, clearable, blocks writes
// RULE16: file format fields read-only on rom cards
// RULE17: format group zero codes; group one reserved
// RULE18: ecc 0 none, 1 bch, 2-3 reserved
// RULE19: host picks user data decoding from ecc
// RULE20: host recomputes checksum on every modification
// RULE21: checksum in bits 7:1, bit 0 one
// RULE22: capacity is size plus one, factor, length
// RULE23: no reserved codes; other fields stay factory
// RULE24: protected write or erase flagged, memory untouched
`timescale 1ns/100ps
`include "csd_consts.svh"
module csd_card_end #(
  parameter logic [`CSD_W-1:0] FACTORY = `CSD_FACTORY,
  parameter bit                IS_ROM  = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // link
  csd_link_if.card         link,
  // memory core strobes
  output logic             memWrStb,
  output logic             memErsStb,
  output logic             grpWpStb,
  output logic [11:0]      memLen,
  // decoded fields
  output logic [11:0]      readCurMinDeci,
  output logic [11:0]      writeCurMinDeci,
  output logic [11:0]      readCurMaxDeci,
  output logic [11:0]      writeCurMaxDeci,
  output logic [9:0]       sizeFactor,
  output logic [5:0]       sectorBlocks,
  output logic [5:0]       groupSectors,
  output logic [5:0]       protectGroups,
  output logic [5:0]       writeTimeFactor,
  output logic [11:0]      readBlockBytes,
  output logic [11:0]      writeBlockBytes,
  output logic [32:0]      capacityBytes,
  output logic [1:0]       eccCorrBits,
  output logic             writeLocked
);
  csd_pkg::csd_card_type st_r;
  csd_pkg::csd_card_type st_nxt;

  // ******
  // decode functions
  // ******
  function automatic logic [11:0] curMinDeci(input logic [2:0] c);
    case (c)
      3'h0:    curMinDeci = 12'h005; // RULE1
      3'h1:    curMinDeci = 12'h00A;
      3'h2:    curMinDeci = 12'h032;
      3'h3:    curMinDeci = 12'h064;
      3'h4:    curMinDeci = 12'h0FA;
      3'h5:    curMinDeci = 12'h15E;
      3'h6:    curMinDeci = 12'h258;
      default: curMinDeci = 12'h3E8;
    endcase
  endfunction

  function automatic logic [11:0] curMaxDeci(input logic [2:0] c);
    case (c)
      3'h0:    curMaxDeci = 12'h00A; // RULE2
      3'h1:    curMaxDeci = 12'h032;
      3'h2:    curMaxDeci = 12'h064;
      3'h3:    curMaxDeci = 12'h0FA;
      3'h4:    curMaxDeci = 12'h15E;
      3'h5:    curMaxDeci = 12'h1C2;
      3'h6:    curMaxDeci = 12'h320;
      default: curMaxDeci = 12'h7D0;
    endcase
  endfunction

  // reserved lengths give zero bytes
  function automatic logic [11:0] blkBytes(input logic [3:0] c);
    blkBytes = (c < 4'hC) ? (12'h001 << c) : 12'h000; // RULE11
  endfunction

  // ******
  // field views
  // ******
  logic [`CSD_W-1:0] csd;
  logic [3:0]        rblCode;
  logic [3:0]        wblCode;
  logic [2:0]        multCode;
  logic [2:0]        r2wCode;
  logic [11:0]       cSize;
  logic              locked;

  assign csd      = st_r.csd;
  assign rblCode  = csd[`CSD_RBL_LSB +: 4];
  assign wblCode  = csd[`CSD_WBL_LSB +: 4];
  assign multCode = csd[`CSD_SIZE_FACTOR_LSB +: 3];
  assign r2wCode  = csd[`CSD_R2W_LSB +: 3];
  assign cSize    = csd[`CSD_CSIZE_LSB +: 12];
  assign locked   = csd[`CSD_PERM_BIT] | csd[`CSD_TMP_BIT]; // RULE14 RULE15

  // ******
  // decoded outputs
  // ******
  assign readCurMinDeci  = curMinDeci(csd[`CSD_RMIN_LSB +: 3]);  // RULE1
  assign writeCurMinDeci = curMinDeci(csd[`CSD_WMIN_LSB +: 3]);  // RULE1
  assign readCurMaxDeci  = curMaxDeci(csd[`CSD_RMAX_LSB +: 3]);  // RULE2
  assign writeCurMaxDeci = curMaxDeci(csd[`CSD_WMAX_LSB +: 3]);  // RULE2
  assign sizeFactor      = 10'h004 << multCode; // RULE3
  assign sectorBlocks    = {1'b0, csd[`CSD_SECT_LSB +: 5]} + 6'h01; // RULE4
  assign groupSectors    = {1'b0, csd[`CSD_EGRP_LSB +: 5]} + 6'h01; // RULE5
  assign protectGroups   = {1'b0, csd[`CSD_WPGRP_LSB +: 5]} + 6'h01; // RULE6
  assign writeTimeFactor = (r2wCode < 3'h6) ? (6'h01 << r2wCode) : 6'h00; // RULE9
  assign readBlockBytes  = blkBytes(rblCode);
  assign writeBlockBytes = blkBytes(wblCode); // RULE10
  assign eccCorrBits     = (csd[`CSD_ECC_LSB +: 2] == 2'h1) ? 2'h3 : 2'h0; // RULE18
  assign writeLocked     = locked;

  always_comb begin
    logic [4:0] sh;
    sh = 5'({2'h0, multCode} + 5'h02 + {1'b0, rblCode});
    capacityBytes = (rblCode < 4'hC) ? ({20'h00000, 13'({1'b0, cSize} + 13'h0001)} << sh) : 33'h0; // RULE22
  end

  // ******
  // command handling
  // ******
  always_comb begin
    logic [`CSD_W-1:0] arg;
    logic [`CSD_W-1:0] upd;
    logic [11:0]       wlen;
    logic              lenOk;
    arg   = link.cmdArg;
    upd   = st_r.csd;
    wlen  = blkBytes(wblCode);
    lenOk = 1'b0;
    st_nxt           = st_r;
    st_nxt.rspValid  = 1'b0;
    st_nxt.memWrStb  = 1'b0;
    st_nxt.memErsStb = 1'b0;
    st_nxt.grpWpStb  = 1'b0;
    if (link.cmdValid) begin
      st_nxt.rspValid  = 1'b1;
      st_nxt.rspData   = st_r.csd;
      st_nxt.rspStatus = 4'h0;
      case (link.cmdOp)
        csd_pkg::OP_READ: begin
          st_nxt.rspStatus[`CSD_ST_OK] = 1'b1;
        end
        csd_pkg::OP_PROG: begin
          // only protection, copy, format, ecc and checksum are writable
          upd[`CSD_COPY_BIT] = st_r.csd[`CSD_COPY_BIT] | arg[`CSD_COPY_BIT]; // RULE13
          upd[`CSD_PERM_BIT] = st_r.csd[`CSD_PERM_BIT] | arg[`CSD_PERM_BIT]; // RULE14
          upd[`CSD_TMP_BIT]  = arg[`CSD_TMP_BIT]; // RULE15
          if (!IS_ROM) begin
            upd[`CSD_FFG_BIT]      = arg[`CSD_FFG_BIT]; // RULE16
            upd[`CSD_FF_LSB +: 2]  = arg[`CSD_FF_LSB +: 2]; // RULE16
          end
          upd[`CSD_ECC_LSB +: 2]  = arg[`CSD_ECC_LSB +: 2];
          upd[`CSD_CRC_LSB +: 7]  = arg[`CSD_CRC_LSB +: 7]; // RULE21
          upd[`CSD_ONE_BIT]       = 1'b1; // RULE21
          // reserved codes are refused and the image is kept
          if (upd[`CSD_ECC_LSB +: 2] > 2'h1 || upd[`CSD_FFG_BIT]) begin // RULE17 RULE18 RULE23
            st_nxt.rspStatus[`CSD_ST_ILLEGAL] = 1'b1;
          end else begin
            st_nxt.csd                   = upd; // RULE8 RULE23
            st_nxt.rspData               = upd;
            st_nxt.rspStatus[`CSD_ST_OK] = 1'b1;
          end
        end
        csd_pkg::OP_WRITE: begin
          if (st_r.csd[`CSD_PART_BIT]) begin
            lenOk = (link.cmdLen != 12'h000) && (link.cmdLen <= wlen); // RULE12
          end else begin
            lenOk = (link.cmdLen == wlen) && (wlen != 12'h000); // RULE12
          end
          if (locked) begin
            st_nxt.rspStatus[`CSD_ST_WP] = 1'b1; // RULE24
          end else if (!lenOk) begin
            st_nxt.rspStatus[`CSD_ST_BLKLEN] = 1'b1;
          end else begin
            st_nxt.memWrStb              = 1'b1;
            st_nxt.memLen                = link.cmdLen;
            st_nxt.rspStatus[`CSD_ST_OK] = 1'b1;
          end
        end
        csd_pkg::OP_ERASE: begin
          if (locked) begin
            st_nxt.rspStatus[`CSD_ST_WP] = 1'b1; // RULE24
          end else begin
            st_nxt.memErsStb             = 1'b1;
            st_nxt.rspStatus[`CSD_ST_OK] = 1'b1;
          end
        end
        csd_pkg::OP_GROUP_WP: begin
          if (!st_r.csd[`CSD_WPEN_BIT]) begin
            st_nxt.rspStatus[`CSD_ST_ILLEGAL] = 1'b1; // RULE7
          end else begin
            st_nxt.grpWpStb              = 1'b1;
            st_nxt.rspStatus[`CSD_ST_OK] = 1'b1;
          end
        end
        default: begin
          st_nxt.rspStatus[`CSD_ST_ILLEGAL] = 1'b1;
        end
      endcase
    end
  end

  // ******
  // state register
  // ******
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r           <= '0;
      st_r.csd       <= FACTORY;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ******
  // outputs
  // ******
  assign link.rspValid  = st_r.rspValid;
  assign link.rspData   = st_r.rspData;
  assign link.rspStatus = st_r.rspStatus;
  assign memWrStb       = st_r.memWrStb;
  assign memErsStb      = st_r.memErsStb;
  assign grpWpStb       = st_r.grpWpStb;
  assign memLen         = st_r.memLen;
endmodule

// ### design/csd_consts.svh
/*
  bit positions, reset values, status bits and register offsets for the
  card specific data register block.
  assumes inclusion by bare name from the package and the two ends.
*/
`ifndef CSD_CONSTS_SVH
`define CSD_CONSTS_SVH

// ******
// register image
// ******
`define CSD_W          128
`define CSD_FACTORY    128'h40000000_009000FF_D34DFFE0_8A400001
`define CSD_RBL_LSB    80
`define CSD_CSIZE_LSB  62
`define CSD_RMIN_LSB   59
`define CSD_RMAX_LSB   56
`define CSD_WMIN_LSB   53
`define CSD_WMAX_LSB   50
`define CSD_SIZE_FACTOR_LSB   47
`define CSD_SECT_LSB   42
`define CSD_EGRP_LSB   37
`define CSD_WPGRP_LSB  32
`define CSD_WPEN_BIT   31
`define CSD_DECC_LSB   29
`define CSD_R2W_LSB    26
`define CSD_WBL_LSB    22
`define CSD_PART_BIT   21
`define CSD_FFG_BIT    15
`define CSD_COPY_BIT   14
`define CSD_PERM_BIT   13
`define CSD_TMP_BIT    12
`define CSD_FF_LSB     10
`define CSD_ECC_LSB    8
`define CSD_CRC_LSB    1
`define CSD_ONE_BIT    0
`define CSD_CRC_DATA_W 120

// ******
// response status bits
// ******
`define CSD_ST_WP      0
`define CSD_ST_BLKLEN  1
`define CSD_ST_ILLEGAL 2
`define CSD_ST_OK      3

// ******
// controller register offsets
// ******
`define CSD_OFS_CTRL   8'h00
`define CSD_OFS_STATUS 8'h04
`define CSD_OFS_LEN    8'h08
`define CSD_OFS_STAGE  8'h10
`define CSD_OFS_RDCSD  8'h20
`define CSD_OFS_ECC    8'h30
`define CSD_RESP_OKAY  2'h0
`define CSD_RESP_SLV   2'h2

`endif

// ### design/csd_crc7.sv
/*
  seven bit checksum, polynomial x^7 + x^3 + 1, msb first, zero start.
  assumes a static data word; purely combinational.
*/
`timescale 1ns/100ps
`include "csd_consts.svh"
module csd_crc7 #(
  parameter int DATA_W = `CSD_CRC_DATA_W
) (
  // data
  input  wire logic [DATA_W-1:0] data,
  // checksum
  output logic      [6:0]        crc
);
  always_comb begin
    logic fb;
    crc = 7'h00;
    fb  = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb  = data[i] ^ crc[6];
      crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
  end
endmodule

// ### design/csd_host_end.sv
/*
  host end: axi4-lite register slave that orders link commands, seals
  programmed images with a fresh checksum and reports the answers.
  assumes the card answers every command on the link.
*/
`timescale 1ns/100ps
`include "csd_consts.svh"
module csd_host_end (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link
  csd_link_if.host         link,
  // user side
  output logic [1:0]       eccDecodeSel,
  output logic             busy
);
  csd_pkg::csd_host_type st_r;
  csd_pkg::csd_host_type st_nxt;
  logic [6:0]            crc;

  csd_crc7 #(.DATA_W(`CSD_CRC_DATA_W)) csd_crc7_inst (
    .data (st_r.stage[`CSD_W-1:8]),
    .crc  (crc)
  );

  // ******
  // address decode
  // ******
  function automatic logic mapped(input logic [7:0] a, input logic wr);
    mapped = (a == `CSD_OFS_CTRL) || (a == `CSD_OFS_STATUS) || (a == `CSD_OFS_LEN) ||
             (a[7:4] == `CSD_OFS_STAGE >> 4 && a[1:0] == 2'h0) ||
             (!wr && ((a[7:4] == `CSD_OFS_RDCSD >> 4 && a[1:0] == 2'h0) || a == `CSD_OFS_ECC));
  endfunction

  assign s_axi_awready = ce & ~st_r.awHave;
  assign s_axi_wready  = ce & ~st_r.wHave;
  assign s_axi_arready = ce & ~st_r.rValid;

  always_comb begin
    logic [7:0] a;
    logic [6:0] wb;
    st_nxt = st_r;
    a      = st_r.awAddr;
    wb     = {st_r.awAddr[3:2], 5'h00};
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    // ******
    // command sequencer
    // ******
    case (st_r.hs)
      csd_pkg::H_IDLE: begin
      end
      csd_pkg::H_SEND: begin
        st_nxt.hs = csd_pkg::H_WAIT;
      end
      csd_pkg::H_WAIT: begin
        if (link.rspValid) begin
          st_nxt.hs     = csd_pkg::H_IDLE;
          st_nxt.status = link.rspStatus;
          if (st_r.op == csd_pkg::OP_READ || st_r.op == csd_pkg::OP_PROG) begin
            st_nxt.rdCsd = link.rspData;
          end
        end
      end
      default: begin
        st_nxt.hs = csd_pkg::H_IDLE;
      end
    endcase
    // ******
    // register write
    // ******
    if (st_r.awHave && st_r.wHave && !st_r.bValid) begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = mapped(a, 1'b1) ? `CSD_RESP_OKAY : `CSD_RESP_SLV;
      if (a == `CSD_OFS_CTRL && st_r.wStrb[0] && st_r.wData[0] && st_r.hs == csd_pkg::H_IDLE) begin
        st_nxt.op     = csd_pkg::csd_op_type'(st_r.wData[3:1]);
        st_nxt.cmdArg = st_r.stage;
        st_nxt.hs     = csd_pkg::H_SEND;
        if (csd_pkg::csd_op_type'(st_r.wData[3:1]) == csd_pkg::OP_PROG) begin
          st_nxt.cmdArg = {st_r.stage[`CSD_W-1:8], crc, 1'b1}; // RULE20
        end
      end
      if (a == `CSD_OFS_STATUS && st_r.wStrb[0] && st_r.wData[4]) begin
        st_nxt.done = 1'b0;
      end
      if (a == `CSD_OFS_LEN) begin
        for (int b = 0; b < 2; b++) begin
          if (st_r.wStrb[b]) begin
            st_nxt.len[b*8 +: 4] = st_r.wData[b*8 +: 4];
          end
        end
        if (st_r.wStrb[0]) begin
          st_nxt.len[7:4] = st_r.wData[7:4];
        end
      end
      if (a[7:4] == `CSD_OFS_STAGE >> 4 && a[1:0] == 2'h0) begin
        for (int b = 0; b < 4; b++) begin
          if (st_r.wStrb[b]) begin
            st_nxt.stage[{wb[6:5], 5'h00} + 7'(b*8) +: 8] = st_r.wData[b*8 +: 8];
          end
        end
      end
    end
    // answer sets done after any clear in the same cycle
    if (st_r.hs == csd_pkg::H_WAIT && link.rspValid) begin
      st_nxt.done = 1'b1;
    end
    // ******
    // register read
    // ******
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = mapped(s_axi_araddr, 1'b0) ? `CSD_RESP_OKAY : `CSD_RESP_SLV;
      st_nxt.rData  = 32'h0;
      case (s_axi_araddr[7:4])
        4'h0: begin
          if (s_axi_araddr == `CSD_OFS_CTRL) st_nxt.rData = {28'h0, st_r.op, st_r.hs != csd_pkg::H_IDLE};
          if (s_axi_araddr == `CSD_OFS_STATUS) st_nxt.rData = {27'h0, st_r.done, st_r.status};
          if (s_axi_araddr == `CSD_OFS_LEN) st_nxt.rData = {20'h0, st_r.len};
        end
        4'h1: st_nxt.rData = st_r.stage[{s_axi_araddr[3:2], 5'h00} +: 32];
        4'h2: st_nxt.rData = st_r.rdCsd[{s_axi_araddr[3:2], 5'h00} +: 32];
        4'h3: st_nxt.rData = {30'h0, st_r.rdCsd[`CSD_ECC_LSB +: 2]};
        default: st_nxt.rData = 32'h0;
      endcase
      if (!mapped(s_axi_araddr, 1'b0)) begin
        st_nxt.rData = 32'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ******
  // outputs
  // ******
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign link.cmdValid = ce & (st_r.hs == csd_pkg::H_SEND);
  assign link.cmdOp    = st_r.op;
  assign link.cmdArg   = st_r.cmdArg;
  assign link.cmdLen   = st_r.len;
  assign eccDecodeSel  = st_r.rdCsd[`CSD_ECC_LSB +: 2]; // RULE19
  assign busy          = st_r.hs != csd_pkg::H_IDLE;
endmodule

// ### design/csd_link_if.sv
/*
  command link between card controller and card register block.
  assumes both ends run on the same clock; the bench joins them.
*/
`timescale 1ns/100ps
`include "csd_consts.svh"
interface csd_link_if;
  logic                cmdValid;
  csd_pkg::csd_op_type cmdOp;
  logic [`CSD_W-1:0]   cmdArg;
  logic [11:0]         cmdLen;
  logic                rspValid;
  logic [`CSD_W-1:0]   rspData;
  logic [3:0]          rspStatus;

  modport card (input cmdValid, cmdOp, cmdArg, cmdLen, output rspValid, rspData, rspStatus);
  modport host (output cmdValid, cmdOp, cmdArg, cmdLen, input rspValid, rspData, rspStatus);
endinterface

// ### design/csd_pkg.sv
/*
  types shared by both ends of the card specific data link.
  assumes csd_consts.svh on the include path.
*/
`include "csd_consts.svh"
package csd_pkg;
  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_PROG     = 3'h1,
    OP_WRITE    = 3'h2,
    OP_ERASE    = 3'h3,
    OP_GROUP_WP = 3'h4
  } csd_op_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SEND = 2'h1,
    H_WAIT = 2'h3
  } csd_hstate_type;

  typedef struct packed {
    logic [`CSD_W-1:0] csd;
    logic              rspValid;
    logic [`CSD_W-1:0] rspData;
    logic [3:0]        rspStatus;
    logic              memWrStb;
    logic              memErsStb;
    logic              grpWpStb;
    logic [11:0]       memLen;
  } csd_card_type;

  typedef struct packed {
    csd_hstate_type    hs;
    logic              awHave;
    logic [7:0]        awAddr;
    logic              wHave;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    csd_op_type        op;
    logic [11:0]       len;
    logic [`CSD_W-1:0] stage;
    logic [`CSD_W-1:0] rdCsd;
    logic [`CSD_W-1:0] cmdArg;
    logic [3:0]        status;
    logic              done;
  } csd_host_type;
endpackage

// ### sim/csd_link_properties.sv
/*
  link checker: timing and field rules seen on the card link.
  assumes one clock and ce held high.
*/
`timescale 1ns/100ps
`include "csd_consts.svh"
// ******
// link properties
// ******
module csd_link_properties (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                arst_n,
  // link
  input wire logic                cmdValid,
  input wire csd_pkg::csd_op_type cmdOp,
  input wire logic [`CSD_W-1:0]   cmdArg,
  input wire logic [11:0]         cmdLen,
  input wire logic                rspValid,
  input wire logic [`CSD_W-1:0]   rspData,
  input wire logic [3:0]          rspStatus
);
  logic rdOp_r;
  logic copy_r;
  logic perm_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // sticky bits seen in read answers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdOp_r <= 1'b0;
      copy_r <= 1'b0;
      perm_r <= 1'b0;
    end else begin
      rdOp_r <= cmdValid && cmdOp == csd_pkg::OP_READ;
      if (rdOp_r && rspValid && rspStatus[3]) begin
        copy_r <= copy_r | rspData[14];
        perm_r <= perm_r | rspData[13];
      end
    end
  end
  sequence s_rd_ok;
    cmdValid && cmdOp == csd_pkg::OP_READ ##1 rspValid && rspStatus[3];
  endsequence
  sequence s_refused;
    rspStatus[2] && !rspStatus[3];
  endsequence
  a_rsp_timing: assert property (cmdValid |=> rspValid ##1 !rspValid)
    else $error("answer not one cycle after command");
  a_lsb_one: assert property (s_rd_ok |-> rspData[0])
    else $error("image bit 0 not one");
  a_no_reserved: assert property (s_rd_ok |-> !rspData[9] && !rspData[15] && rspData[28:26] < 3'h6
    && rspData[83:80] < 4'hC && rspData[25:22] < 4'hC) else $error("reserved code reported");
  a_copy_sticky: assert property (s_rd_ok |-> !copy_r || rspData[14])
    else $error("copy flag cleared");
  a_perm_sticky: assert property (s_rd_ok |-> !perm_r || rspData[13])
    else $error("permanent lock cleared");
  a_perm_blocks: assert property (cmdValid && perm_r && cmdOp inside {csd_pkg::OP_WRITE, csd_pkg::OP_ERASE}
    |=> rspStatus[0] && !rspStatus[3]) else $error("locked write accepted");
  a_ecc_refused: assert property (cmdValid && cmdOp == csd_pkg::OP_PROG && cmdArg[9] |=> s_refused)
    else $error("reserved ecc accepted");
  a_fmt_refused: assert property (cmdValid && cmdOp == csd_pkg::OP_PROG && cmdArg[15] |=> s_refused)
    else $error("reserved format group accepted");
  a_len_zero: assert property (cmdValid && cmdOp == csd_pkg::OP_WRITE && cmdLen == 12'h000 |=> !rspStatus[3])
    else $error("empty write accepted");
endmodule

// ### sim/tb_card_specific_data_fields.sv
/*
  bench: host end and card end joined by the link, driven over axi4-lite.
  assumes the design files are compiled first.
*/
`timescale 1ns/100ps
`include "csd_consts.svh"
// ******
// bench
// ******
module tb_card_specific_data_fields;
  localparam logic [127:0] F = `CSD_FACTORY;
  localparam logic [11:0] MINT [8] = '{12'h005, 12'h00A, 12'h032, 12'h064, 12'h0FA, 12'h15E, 12'h258, 12'h3E8};
  localparam logic [11:0] MAXT [8] = '{12'h00A, 12'h032, 12'h064, 12'h0FA, 12'h15E, 12'h1C2, 12'h320, 12'h7D0};
  logic ref_clk = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy, writeLocked;
  logic memWrStb, memErsStb, grpWpStb;
  logic [1:0] s_axi_bresp, s_axi_rresp, eccDecodeSel, eccCorrBits;
  logic [11:0] memLen, readCurMinDeci, writeCurMinDeci, readCurMaxDeci, writeCurMaxDeci, readBlockBytes, writeBlockBytes;
  logic [9:0] sizeFactor;
  logic [5:0] sectorBlocks, groupSectors, protectGroups, writeTimeFactor;
  logic [32:0] capacityBytes;
  logic [127:0] v;
  int fails = 0, n_checks = 0, cyc = 0, nMem = 0;
  csd_link_if link ();
  csd_card_end csd_card_end_inst (.*, .ce(1'b1));
  csd_host_end csd_host_end_inst (.*, .ce(1'b1));
  csd_link_properties csd_link_properties_inst (.ref_clk, .arst_n, .cmdValid(link.cmdValid), .cmdOp(link.cmdOp),
    .cmdArg(link.cmdArg), .cmdLen(link.cmdLen), .rspValid(link.rspValid), .rspData(link.rspData),
    .rspStatus(link.rspStatus));
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (memWrStb || memErsStb || grpWpStb) nMem++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic cmd(input logic [2:0] op, output logic [3:0] st);
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h00, {28'h0000000, op, 1'b1});
    do rd(8'h04, d, r); while (d[4] !== 1'b1);
    st = d[3:0];
    chk(busy, 1'b0);
    wr(8'h04, 32'h00000010);
  endtask
  task automatic img(output logic [127:0] e);
    logic [3:0] st;
    logic [1:0] r;
    cmd(3'h0, st);
    for (int i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), e[32 * i +: 32], r);
  endtask
  task automatic prog(input logic [3:0] x);
    logic [3:0] st;
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), v[32 * i +: 32]);
    cmd(3'h1, st);
    chk(st, x);
  endtask
  task automatic t_decode;
    logic [3:0] rb;
    rb = F[83:80];
    chk(readCurMinDeci, MINT[F[61:59]]);
    chk(writeCurMinDeci, MINT[F[55:53]]);
    chk(readCurMaxDeci, MAXT[F[58:56]]);
    chk(writeCurMaxDeci, MAXT[F[52:50]]);
    chk(sizeFactor, 10'h001 << (F[49:47] + 2));
    chk(sectorBlocks, F[46:42] + 6'h01);
    chk(groupSectors, F[41:37] + 6'h01);
    chk(protectGroups, F[36:32] + 6'h01);
    chk(writeTimeFactor, F[28:26] < 3'h6 ? 6'h01 << F[28:26] : 6'h00);
    chk(readBlockBytes, rb < 4'hC ? 12'h001 << rb : 12'h000);
    chk(writeBlockBytes, F[25:22] < 4'hC ? 12'h001 << F[25:22] : 12'h000);
    chk(capacityBytes, rb < 4'hC ? (33'(F[73:62]) + 33'h1) << (F[49:47] + 2 + rb) : 33'h0);
    chk(eccCorrBits, F[9:8] == 2'h1 ? 2'h3 : 2'h0);
  endtask
  task automatic t_prog;
    logic [127:0] e;
    img(v);
    chk(v, F | 128'h1);
    v[14] = 1'b1;
    v[12] = 1'b1;
    v[9:8] = 2'h1;
    prog(4'h8);
    img(e);
    chk(e, {v[127:8], crc7(v[127:8]), 1'b1});
    chk(eccDecodeSel, 2'h1);
    chk(eccCorrBits, 2'h3);
    chk(writeLocked, 1'b1);
  endtask
  task automatic t_lock;
    logic [127:0] e;
    logic [3:0] st;
    int n;
    wr(8'h08, {20'h00000, 12'h001 << F[25:22]});
    n = nMem;
    cmd(3'h2, st);
    chk(st, 4'h1);
    cmd(3'h3, st);
    chk(st, 4'h1);
    chk(nMem, n);
    v[14] = 1'b0;
    v[12] = 1'b0;
    prog(4'h8);
    img(e);
    chk(e[14], 1'b1);
    chk(e[30:29], F[30:29]);
    chk(writeLocked, 1'b0);
    cmd(3'h2, st);
    chk(st, 4'h8);
    chk(memLen, 12'h001 << F[25:22]);
    wr(8'h08, 32'h0);
    cmd(3'h2, st);
    chk(st, 4'h2);
    chk(nMem, n + 1);
  endtask
  task automatic t_refuse;
    logic [127:0] e;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] st;
    int n;
    v[9:8] = 2'h2;
    prog(4'h4);
    v[9:8] = 2'h0;
    v[15] = 1'b1;
    prog(4'h4);
    v[15] = 1'b0;
    v[13] = 1'b1;
    prog(4'h8);
    img(e);
    cmd(3'h3, st);
    chk(st, 4'h1);
    v[13] = 1'b0;
    prog(4'h8);
    img(e);
    chk(e[13], 1'b1);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    n = nMem;
    cmd(3'h4, st);
    chk(st, 4'h8);
    chk(nMem, n + 1);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_decode();
    t_prog();
    t_lock();
    t_refuse();
    conclude();
  end
endmodule
